/* logic/qdsl_pkg.sv */
`default_nettype none
package qdsl_pkg;
    localparam int WORD_BITS = 16;
    localparam int CODE_BITS = 12;
    localparam int CHANNELS = 4;
    localparam int CNT_BITS = 5;
    localparam int SEL_BITS = 2;
    localparam int COUNT_BITS = 8;
    localparam logic [CNT_BITS-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_BITS-1:0] CNT_ONE = 5'h01;
    localparam logic [CNT_BITS-1:0] CNT_LAST = 5'h0F;
    localparam logic [CNT_BITS-1:0] CNT_DONE = 5'h10;
    localparam logic [WORD_BITS-1:0] WORD_ZERO = 16'h0000;
    localparam logic [CODE_BITS-1:0] ZERO_CODE = 12'h000;
    localparam logic [COUNT_BITS-1:0] COUNT_ZERO = 8'h00;
    localparam logic [COUNT_BITS-1:0] COUNT_ONE = 8'h01;
    localparam logic [1:0] SETTLE_ZERO = 2'h0;
    localparam logic [1:0] SETTLE_ONE = 2'h1;
    localparam logic [1:0] SETTLE_CYCLES = 2'h3;
    // Shift clock ceiling and system clock rate
    localparam int SHIFT_MAX_MHZ = 40;
    localparam int REF_CLK_MHZ = 200;
    localparam int SHIFT_MIN_REF_CYCLES = (REF_CLK_MHZ + SHIFT_MAX_MHZ - 1) / SHIFT_MAX_MHZ;

    typedef enum logic [1:0] {
        MODE_WRITE = 2'b00,
        MODE_WRITE_ONE = 2'b01,
        MODE_WRITE_ALL = 2'b10,
        MODE_POWER_DOWN = 2'b11
    } qdsl_mode_t;

    typedef enum logic [1:0] {
        TERM_2K5 = 2'b00,
        TERM_100K = 2'b01,
        TERM_HIZ = 2'b10
    } qdsl_term_t;

    // Word layout, most significant bit shifted first
    typedef struct packed {
        logic [SEL_BITS-1:0] sel;
        qdsl_mode_t mode;
        logic [CODE_BITS-1:0] code;
    } qdsl_word_t;

    typedef struct packed {
        logic powerDown;
        qdsl_term_t termination;
        logic loaded;
        logic frameActive;
    } qdsl_status_t;
endpackage
`default_nettype wire

/* logic/qdsl_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module qdsl_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage1_q;

    // Two flops; the first is read by the second only
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            stage1_q <= '0;
            synced <= '0;
        end else begin
            stage1_q <= async;
            synced <= stage1_q;
        end
    end
endmodule
`default_nettype wire

/* logic/qdsl_shift.sv */
`timescale 1ns/10ps
`default_nettype none
module qdsl_shift (
    input wire logic shiftClk,
    input wire logic resetn,
    input wire logic frameStrobeN,
    input wire logic serialIn,
    output logic [qdsl_pkg::WORD_BITS-1:0] wordOut,
    output logic wordToggle
);
    import qdsl_pkg::*;

    logic [WORD_BITS-1:0] shift_q;
    logic [CNT_BITS-1:0] count_q;
    logic linkClear;

    // The shift clock stops between frames, so the strobe itself clears the frame state
    assign linkClear = frameStrobeN | ~resetn;

    // Shift on falling edges while the strobe is low, freeze after 16 bits
    always_ff @(negedge shiftClk or posedge linkClear) begin
        if (linkClear) begin
            shift_q <= WORD_ZERO;
            count_q <= CNT_ZERO;
        end else if (count_q != CNT_DONE) begin
            shift_q <= {shift_q[WORD_BITS-2:0], serialIn};
            count_q <= count_q + CNT_ONE;
        end
    end

    // Hand the whole word over on the 16th edge; held until the next full word
    always_ff @(negedge shiftClk or negedge resetn) begin
        if (!resetn) begin
            wordOut <= WORD_ZERO;
            wordToggle <= 1'b0;
        end else if (!frameStrobeN && count_q == CNT_LAST) begin
            wordOut <= {shift_q[WORD_BITS-2:0], serialIn};
            wordToggle <= ~wordToggle;
        end
    end
endmodule
`default_nettype wire

/* logic/qdsl_loader.sv */
`timescale 1ns/10ps
`default_nettype none
module qdsl_loader (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic shiftClk,
    input wire logic frameStrobeN,
    input wire logic serialIn,
    output logic [qdsl_pkg::CODE_BITS-1:0] channelAOutput,
    output logic [qdsl_pkg::CODE_BITS-1:0] channelBOutput,
    output logic [qdsl_pkg::CODE_BITS-1:0] channelCOutput,
    output logic [qdsl_pkg::CODE_BITS-1:0] channelDOutput,
    output logic [qdsl_pkg::CHANNELS-1:0] pendingUpdate,
    output qdsl_pkg::qdsl_status_t status,
    output logic [qdsl_pkg::WORD_BITS-1:0] lastWord,
    output logic wordApplied,
    output logic frameAborted,
    output logic [qdsl_pkg::COUNT_BITS-1:0] appliedCount,
    output logic [qdsl_pkg::COUNT_BITS-1:0] abortCount
);
    import qdsl_pkg::*;

    logic [WORD_BITS-1:0] linkWord;
    logic linkToggle;
    logic toggleSync;
    logic frameSync;
    logic toggle_q;
    logic strobe_q;
    logic newWord;
    logic strobeRise;
    logic strobeFall;
    qdsl_word_t word;
    logic [CODE_BITS-1:0] input_q [CHANNELS];
    logic [CODE_BITS-1:0] output_q [CHANNELS];
    logic powerDown_q;
    qdsl_term_t term_q;
    logic loaded_q;
    logic wordSeen_q;
    logic [1:0] settle_q;
    logic settling_q;
    logic updateAll;
    logic updateOne;
    logic writeOne;
    logic [CHANNELS-1:0] selHit;

    // Link-side shifter on the shift clock
    qdsl_shift u_shift (
        .shiftClk(shiftClk),
        .resetn(resetn),
        .frameStrobeN(frameStrobeN),
        .serialIn(serialIn),
        .wordOut(linkWord),
        .wordToggle(linkToggle)
    );

    // Event toggle crosses to ref_clk; the word stays still far longer than the crossing
    qdsl_sync #(
        .WIDTH(1)
    ) u_toggleSync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async(linkToggle),
        .synced(toggleSync)
    );

    // Strobe crosses inverted, so the cleared synchroniser reads as an idle link
    // and no false strobe edge follows reset
    qdsl_sync #(
        .WIDTH(1)
    ) u_strobeSync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .async(~frameStrobeN),
        .synced(frameSync)
    );

    // Delayed copies for edge detection on synchronised signals only
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            toggle_q <= 1'b0;
            strobe_q <= 1'b0;
        end else begin
            toggle_q <= toggleSync;
            strobe_q <= frameSync;
        end
    end

    assign newWord = toggleSync ^ toggle_q;
    assign strobeRise = ~frameSync & strobe_q;
    assign strobeFall = frameSync & ~strobe_q;

    // The crossed word is stable here: a new one needs 16 more shift edges
    assign word = qdsl_word_t'(linkWord);

    // Decode the mode field of a freshly arrived word
    always_comb begin
        writeOne = 1'b0;
        updateOne = 1'b0;
        updateAll = 1'b0;
        if (newWord) begin
            unique case (word.mode)
                MODE_WRITE: begin
                    writeOne = 1'b1;
                end
                MODE_WRITE_ONE: begin
                    writeOne = 1'b1;
                    updateOne = 1'b1;
                end
                MODE_WRITE_ALL: begin
                    writeOne = 1'b1;
                    updateAll = 1'b1;
                end
                MODE_POWER_DOWN: begin
                    writeOne = 1'b0;
                end
            endcase
        end
    end

    // Per-channel input and output code registers
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            assign selHit[ch] = (word.sel == SEL_BITS'(ch));

            // Input register takes the code of a write aimed at this channel
            always_ff @(posedge ref_clk) begin
                if (!resetn) begin
                    input_q[ch] <= ZERO_CODE;
                end else if (writeOne && selHit[ch]) begin
                    input_q[ch] <= word.code;
                end
            end

            // Output follows alone or together with the others
            always_ff @(posedge ref_clk) begin
                if (!resetn) begin
                    output_q[ch] <= ZERO_CODE;
                end else if (updateOne && selHit[ch]) begin
                    output_q[ch] <= word.code;
                end else if (updateAll && selHit[ch]) begin
                    output_q[ch] <= word.code;
                end else if (updateAll) begin
                    output_q[ch] <= input_q[ch];
                end
            end

            // Marks a code written but not yet on the output
            always_ff @(posedge ref_clk) begin
                if (!resetn) begin
                    pendingUpdate[ch] <= 1'b0;
                end else if (updateAll || (updateOne && selHit[ch])) begin
                    pendingUpdate[ch] <= 1'b0;
                end else if (writeOne && selHit[ch]) begin
                    pendingUpdate[ch] <= 1'b1;
                end
            end
        end
    endgenerate

    assign channelAOutput = output_q[0];
    assign channelBOutput = output_q[1];
    assign channelCOutput = output_q[2];
    assign channelDOutput = output_q[3];

    // Power-down entry picks the termination; any output update wakes the outputs
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            powerDown_q <= 1'b0;
            term_q <= TERM_HIZ;
        end else if (newWord && word.mode == MODE_POWER_DOWN) begin
            powerDown_q <= 1'b1;
            unique case (word.sel)
                2'b00: term_q <= TERM_2K5;
                2'b01: term_q <= TERM_100K;
                default: term_q <= TERM_HIZ;
            endcase
        end else if (updateOne || updateAll) begin
            powerDown_q <= 1'b0;
        end
    end

    // Remember that a full word has arrived since reset
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            loaded_q <= 1'b0;
        end else if (newWord) begin
            loaded_q <= 1'b1;
        end
    end

    // Copy of the last word applied, for software inspection
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            lastWord <= WORD_ZERO;
        end else if (newWord) begin
            lastWord <= linkWord;
        end
    end

    // One pulse per applied word
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wordApplied <= 1'b0;
        end else begin
            wordApplied <= newWord;
        end
    end

    // Wrapping count of applied words
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            appliedCount <= COUNT_ZERO;
        end else if (newWord) begin
            appliedCount <= appliedCount + COUNT_ONE;
        end
    end

    // A word seen in this frame; the set wins over the clear at frame start
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wordSeen_q <= 1'b0;
        end else if (newWord) begin
            wordSeen_q <= 1'b1;
        end else if (strobeFall) begin
            wordSeen_q <= 1'b0;
        end
    end

    // Both crossings share the same latency, so wait a little after the
    // strobe rises before judging whether the frame completed
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            settling_q <= 1'b0;
            settle_q <= SETTLE_ZERO;
        end else if (strobeRise) begin
            settling_q <= 1'b1;
            settle_q <= SETTLE_ZERO;
        end else if (settling_q && settle_q == SETTLE_CYCLES) begin
            settling_q <= 1'b0;
        end else if (settling_q) begin
            settle_q <= settle_q + SETTLE_ONE;
        end
    end

    // Frame closed with no word: it was aborted and nothing changed
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            frameAborted <= 1'b0;
        end else begin
            frameAborted <= settling_q && settle_q == SETTLE_CYCLES && !wordSeen_q;
        end
    end

    // Wrapping count of aborted frames
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            abortCount <= COUNT_ZERO;
        end else if (settling_q && settle_q == SETTLE_CYCLES && !wordSeen_q) begin
            abortCount <= abortCount + COUNT_ONE;
        end
    end

    // Status bundle; frameActive lags the pin by the synchroniser and this status register
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            status <= '{powerDown: 1'b0, termination: TERM_HIZ, loaded: 1'b0,
                        frameActive: 1'b0};
        end else begin
            status <= '{powerDown: powerDown_q, termination: term_q, loaded: loaded_q,
                        frameActive: frameSync};
        end
    end
endmodule
`default_nettype wire

/* tb/qdsl_loader_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module qdsl_loader_checker (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic shiftClk,
    input wire logic frameStrobeN,
    input wire logic serialIn,
    input wire logic [qdsl_pkg::CODE_BITS-1:0] channelAOutput,
    input wire logic [qdsl_pkg::CODE_BITS-1:0] channelBOutput,
    input wire logic [qdsl_pkg::CODE_BITS-1:0] channelCOutput,
    input wire logic [qdsl_pkg::CODE_BITS-1:0] channelDOutput,
    input wire logic [qdsl_pkg::CHANNELS-1:0] pendingUpdate,
    input wire qdsl_pkg::qdsl_status_t status,
    input wire logic [qdsl_pkg::WORD_BITS-1:0] lastWord,
    input wire logic wordApplied,
    input wire logic frameAborted,
    input wire logic [qdsl_pkg::COUNT_BITS-1:0] appliedCount,
    input wire logic [qdsl_pkg::COUNT_BITS-1:0] abortCount
);
    import qdsl_pkg::*;
    logic [CODE_BITS-1:0] selOut;
    logic [4*CODE_BITS-1:0] allOut;
    // Output named by the select field of the last applied word
    assign selOut = lastWord[15] ? (lastWord[14] ? channelDOutput : channelCOutput)
                                 : (lastWord[14] ? channelBOutput : channelAOutput);
    assign allOut = {channelAOutput, channelBOutput, channelCOutput, channelDOutput};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // Words that move an output, and power-down words
    sequence s_update;
        wordApplied && (lastWord[13:12] == 2'h1 || lastWord[13:12] == 2'h2);
    endsequence
    sequence s_down;
        wordApplied && lastWord[13:12] == 2'h3;
    endsequence
    a_reset_zero: assert property ($rose(resetn) |-> allOut == 48'h0 && !wordApplied)
        else $error("outputs not zero after reset");
    a_applied_pulse: assert property (wordApplied |=> !wordApplied)
        else $error("applied pulse too long");
    a_abort_pulse: assert property (frameAborted |=> !frameAborted)
        else $error("abort pulse too long");
    a_quiet_hold: assert property (!wordApplied |-> $stable(allOut))
        else $error("outputs moved without a word");
    a_update_code: assert property (s_update |-> selOut == lastWord[11:0])
        else $error("selected output lacks the code");
    a_single_only: assert property (s_update and lastWord[13:12] == 2'h1 && lastWord[15:14] != 2'h0
        |-> $stable(channelAOutput))
        else $error("single update touched another output");
    a_down_term: assert property (s_down |=> status.powerDown &&
        status.termination == (lastWord[15] ? 2'h2 : {1'b0, lastWord[14]}))
        else $error("power-down termination wrong");
    a_down_codes: assert property (s_down |-> $stable(allOut))
        else $error("power-down changed a code");
    a_applied_count: assert property (wordApplied |-> appliedCount == $past(appliedCount) + 8'h01)
        else $error("applied count not stepped");
    a_abort_count: assert property (frameAborted |-> abortCount == $past(abortCount) + 8'h01
        && $stable(lastWord))
        else $error("abort count or word wrong");
endmodule
bind qdsl_loader qdsl_loader_checker u_chk (.ref_clk(ref_clk), .resetn(resetn),
    .shiftClk(shiftClk), .frameStrobeN(frameStrobeN), .serialIn(serialIn),
    .channelAOutput(channelAOutput), .channelBOutput(channelBOutput),
    .channelCOutput(channelCOutput), .channelDOutput(channelDOutput),
    .pendingUpdate(pendingUpdate), .status(status), .lastWord(lastWord),
    .wordApplied(wordApplied), .frameAborted(frameAborted),
    .appliedCount(appliedCount), .abortCount(abortCount));
`default_nettype wire

/* tb/qdsl_host.sv */
`timescale 1ns/10ps
`default_nettype none
module qdsl_host (
    output logic shiftClk,
    output logic frameStrobeN,
    output logic serialIn
);
    localparam real HALF = 62.5;
    // Link idles with clock stopped high and no frame open
    initial begin
        shiftClk = 1'b1;
        frameStrobeN = 1'b1;
        serialIn = 1'b0;
    end
    // Bits past the word toggle, so a stale value is never reused
    task automatic send(input logic [15:0] w, input int n);
        frameStrobeN = 1'b0;
        for (int i = 0; i < n; i++) begin
            serialIn = (i < 16) ? w[15 - i] : ~serialIn;
            #HALF shiftClk = 1'b0;
            #HALF shiftClk = 1'b1;
        end
        #30 frameStrobeN = 1'b1;
        serialIn = ~serialIn;
        #130;
    endtask
endmodule
`default_nettype wire

/* tb/qdsl_loader_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module qdsl_loader_bench;
    import qdsl_pkg::*;
    logic ref_clk;
    logic resetn;
    wire logic shiftClk;
    wire logic frameStrobeN;
    wire logic serialIn;
    logic [CODE_BITS-1:0] chA, chB, chC, chD;
    logic [CHANNELS-1:0] pendingUpdate;
    qdsl_status_t status;
    logic [WORD_BITS-1:0] lastWord;
    logic wordApplied, frameAborted;
    logic [COUNT_BITS-1:0] appliedCount, abortCount;
    int errTotal;
    int samplesChecked;

    qdsl_host u_host (.shiftClk(shiftClk), .frameStrobeN(frameStrobeN), .serialIn(serialIn));
    qdsl_loader u_dut (.ref_clk(ref_clk), .resetn(resetn), .shiftClk(shiftClk),
        .frameStrobeN(frameStrobeN), .serialIn(serialIn), .channelAOutput(chA),
        .channelBOutput(chB), .channelCOutput(chC), .channelDOutput(chD),
        .pendingUpdate(pendingUpdate), .status(status), .lastWord(lastWord),
        .wordApplied(wordApplied), .frameAborted(frameAborted),
        .appliedCount(appliedCount), .abortCount(abortCount));

    // System clock, 5 ns
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errTotal++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Bounded wait for the applied or aborted pulse
    task automatic wait_pulse(input bit onAbort);
        for (int i = 0; i < 1000; i++) begin
            @(negedge ref_clk);
            if ((onAbort ? frameAborted : wordApplied) === 1'b1) return;
        end
        errTotal++;
        $display("CHECK FAILED at %0t: no pulse seen", $time);
        stop_test();
    endtask

    // Host frame in parallel with the watch; status lags one cycle
    task automatic frame(input logic [15:0] w, input int n, input bit onAbort);
        fork
            u_host.send(w, n);
            wait_pulse(onAbort);
        join
        @(negedge ref_clk);
    endtask

    // Main sequence
    initial begin
        errTotal = 0;
        samplesChecked = 0;
        resetn = 1'b0;
        repeat (3) @(negedge ref_clk);
        resetn = 1'b1;
        @(negedge ref_clk);
        check({chA, chB, chC, chD}, 48'h0);
        check(status.termination, 2'h2);
        repeat (2) @(negedge ref_clk);
        frame(16'h5ABC, 16, 1'b0);
        check({chA, chB, chC, chD}, 48'h000ABC000000);
        frame(16'h8123, 16, 1'b0);
        check({chA, chB, chC, chD}, 48'h000ABC000000);
        check(pendingUpdate, 4'h4);
        frame(16'h2456, 16, 1'b0);
        check({chA, chB, chC, chD}, 48'h456ABC123000);
        check(pendingUpdate, 4'h0);
        frame(16'hDFFF, 10, 1'b1);
        check({chA, chB, chC, chD}, 48'h456ABC123000);
        check(lastWord, 16'h2456);
        check(abortCount, 8'h01);
        for (int s = 0; s < 3; s++) begin
            frame({s[1:0], 2'h3, 12'h000}, 16, 1'b0);
            check(status.powerDown, 1'b1);
            check(status.termination, s[1:0]);
            check({chA, chB, chC, chD}, 48'h456ABC123000);
        end
        frame(16'hD777, 20, 1'b0);
        check({chA, chB, chC, chD}, 48'h456ABC123777);
        check(status.powerDown, 1'b0);
        repeat (20) @(negedge ref_clk);
        check(appliedCount, 8'h07);
        check(lastWord, 16'hD777);
        check(abortCount, 8'h01);
        stop_test();
    end
endmodule
`default_nettype wire
